// File: verilog/bcc_pkg.sv
// Constants for the bridge class code and status identification block.
// Assumes a dword-wide configuration access port on the core clock.
package bcc_pkg;
  // Configuration access widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  // Byte offsets of the dwords served here
  localparam logic [7:0] CMD_STAT_OFF = 8'h04;
  localparam logic [7:0] CLASS_REV_OFF = 8'h08;
  // Dword index positions within a byte address
  localparam int DW_LSB = 2;
  localparam int DW_MSB = 7;
  // Status halfword sits in the upper half of the command/status dword
  localparam int STAT_LSB = 16;
  localparam int STAT_RSVD_LSB = 0;
  localparam int STAT_RSVD_MSB = 2;
  localparam int STAT_INT_BIT = 3;
  localparam int STAT_CAP_BIT = 4;
  localparam logic [2:0] STAT_RSVD_VAL = 3'h0;
  localparam logic STAT_INT_VAL = 1'b0;
  localparam logic STAT_CAP_VAL = 1'b1;
  // Class code fields
  localparam logic [7:0] BASE_CLASS_VAL = 8'h06;
  localparam logic [7:0] SUB_CLASS_VAL = 8'h04;
  localparam logic [7:0] PROG_IF_VAL = 8'h00;
  localparam int BASE_LSB = 24;
  localparam int SUB_LSB = 16;
  localparam int PROG_LSB = 8;
  localparam int REV_LSB = 0;
  // Silicon revision default; value is arbitrary
  localparam logic [7:0] REV_DEFAULT = 8'hA5;
  // Answer comes one clock after the request is taken
  localparam int ACK_LAT = 1;
  // Reset value of the read data register
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// File: verilog/bcc_class_regs.sv
// Read-only identification dwords of the bridge configuration header:
// the low status bits and the class code and revision word.
// Assumes config requests arrive as one-cycle strobes on the core clock,
// already decoded to this function by the upstream transaction logic.
// Only whole dwords are answered; byte enables never narrow a read.
// No state here can be changed by software; every image is fixed.
//
// Notes on behaviour
// R01: Status bits 2:0 always read zero
// R02: Interrupt status bit 3 never set
// R03: Class word at 08h ignores writes
// R04: Top class byte reads 06h, bridge
// R05: Second byte reads subclass 04h
// R06: Programming interface byte reads 00h
// R07: Low byte is fixed silicon revision
// R08: Capabilities list bit 4 reads one
`timescale 1ns/1ns

module bcc_class_regs #(
  // Silicon revision code; value is arbitrary
  parameter logic [7:0] REVISION = bcc_pkg::REV_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration request
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [bcc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [bcc_pkg::BE_W-1:0] cfg_be,
  input wire logic [bcc_pkg::DATA_W-1:0] cfg_wdata,
  // Configuration answer
  output logic cfg_ack,
  output logic [bcc_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_hit
);
  import bcc_pkg::*;

  // Registered answer state
  // Three registers carry the whole answer; everything else is combinational
  logic ack_r;
  logic ack_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;

  // Dword decode of the incoming byte address
  wire logic [DW_MSB-DW_LSB:0] req_dw;
  wire logic sel_stat;
  wire logic sel_class;
  wire logic sel_any;
  // Constant field images
  wire logic [15:0] stat_word;
  wire logic [DATA_W-1:0] stat_dword;
  wire logic [DATA_W-1:0] class_word;
  wire logic [DATA_W-1:0] read_mux;
  // Write data and lanes are accepted but nothing here is writable
  wire logic unused_ok;

  // Address bits 1:0 are ignored, so any byte address picks its dword
  assign req_dw = cfg_addr[DW_MSB:DW_LSB];

  // Address decoding as an if / else-if style chain of selects
  assign sel_stat = (req_dw == CMD_STAT_OFF[DW_MSB:DW_LSB]);
  assign sel_class = !sel_stat &&
                     (req_dw == CLASS_REV_OFF[DW_MSB:DW_LSB]);
  assign sel_any = sel_stat || sel_class;

  // Status halfword: only the low five bits are served here; the upper
  // error and capability bits belong to other logic and read zero.
  assign stat_word = {11'h000,
                      STAT_CAP_VAL,   // R08
                      STAT_INT_VAL,   // R02
                      STAT_RSVD_VAL}; // R01
  // Command half is outside this block and reads zero
  assign stat_dword = {stat_word, 16'h0000};

  // Class code word built only from constants, so no write can reach it
  // A field change is a silicon change: edit the package, not this file
  assign class_word = {BASE_CLASS_VAL, // R04
                       SUB_CLASS_VAL,  // R05
                       PROG_IF_VAL,    // R06
                       REVISION};      // R07

  // Read selection; unmapped dwords answer zero so the host never hangs
  assign read_mux = sel_stat ? stat_dword :
                    sel_class ? class_word : RDATA_RST;

  // Fold the ignored inputs so they count as read; the result is unused
  assign unused_ok = ^{cfg_be, cfg_wdata};

  // Next answer: every request is acked one cycle later. Writes are
  // dropped, which keeps the identity word fixed, and return zero data.
  always_comb begin
    ack_nxt = cfg_req;
    hit_nxt = cfg_req && sel_any;
    rdata_nxt = RDATA_RST;
    // Reads take the selected image; writes and idle cycles give zero
    if (cfg_req && !cfg_we) begin
      rdata_nxt = read_mux;
    end else if (cfg_req && cfg_we) begin
      rdata_nxt = RDATA_RST; // R03
    end
  end

  // Answer flops; data holds until the next request to ease sampling
  // Synchronous reset, in the same core clock domain as the host
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      hit_r <= 1'b0;
      rdata_r <= RDATA_RST;
    end else begin
      ack_r <= ack_nxt;
      hit_r <= hit_nxt;
      if (cfg_req) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // Outputs straight from the flops, so no decode glitch reaches them
  assign cfg_ack = ack_r;
  assign cfg_hit = hit_r;
  assign cfg_rdata = rdata_r;

  // Checks below watch the answer port one cycle after each request, except the ack timing check, which runs every cycle, and the hold and reset checks at the end
  // Status reserved bits read as zero
  status_rsvd_a: assert property (@(posedge clk) disable iff (rst) // R01
    cfg_req && !cfg_we && sel_stat |=> cfg_ack &&
    cfg_rdata[STAT_LSB+STAT_RSVD_MSB:STAT_LSB+STAT_RSVD_LSB] == 3'h0)
    else $error("status reserved bits not zero");

  // Interrupt status never reported
  int_status_a: assert property (@(posedge clk) disable iff (rst) // R02
    cfg_req && !cfg_we && sel_stat |=> !cfg_rdata[STAT_LSB+STAT_INT_BIT])
    else $error("interrupt status bit set");

  // Capability chain flag reads one
  cap_chain_a: assert property (@(posedge clk) disable iff (rst) // R08
    cfg_req && !cfg_we && sel_stat |=> cfg_rdata[STAT_LSB+STAT_CAP_BIT])
    else $error("capability chain bit not set");

  // A write to the class word, then a read, still sees the constants
  class_write_a: assert property (@(posedge clk) disable iff (rst) // R03
    cfg_req && cfg_we && sel_class ##1 cfg_req && !cfg_we && sel_class
    |=> cfg_rdata == {8'h06, 8'h04, 8'h00, REVISION})
    else $error("class word changed after write");

  // Base class byte
  base_class_a: assert property (@(posedge clk) disable iff (rst) // R04
    cfg_req && !cfg_we && sel_class |=> cfg_ack &&
    cfg_rdata[BASE_LSB+7:BASE_LSB] == 8'h06)
    else $error("base class byte wrong");

  // Subclass byte
  sub_class_a: assert property (@(posedge clk) disable iff (rst) // R05
    cfg_req && !cfg_we && sel_class |=>
    cfg_rdata[SUB_LSB+7:SUB_LSB] == 8'h04)
    else $error("subclass byte wrong");

  // Programming interface byte
  prog_if_a: assert property (@(posedge clk) disable iff (rst) // R06
    cfg_req && !cfg_we && sel_class |=>
    cfg_rdata[PROG_LSB+7:PROG_LSB] == 8'h00)
    else $error("programming interface byte wrong");

  // Revision byte equals the fixed silicon code
  revision_a: assert property (@(posedge clk) disable iff (rst) // R07
    cfg_req && !cfg_we && sel_class |=>
    cfg_rdata[REV_LSB+7:REV_LSB] == REVISION && cfg_hit)
    else $error("revision byte wrong");

  // Every request answered exactly one cycle later, and never otherwise
  // It also keeps the hit flag from showing without an ack
  ack_timing_a: assert property (@(posedge clk) disable iff (rst)
    cfg_ack == $past(cfg_req) && (!cfg_hit || cfg_ack))
    else $error("answer timing wrong");

  // A write is answered with zero data, as the write path drops it
  write_answer_a: assert property (@(posedge clk) disable iff (rst) // R03
    cfg_req && cfg_we |=> cfg_ack && cfg_rdata == 32'h0000_0000)
    else $error("write answer data not zero");

  // Status dword shows nothing outside the five low status bits; the
  // command half and the upper status bits live in other logic
  status_upper_a: assert property (@(posedge clk) disable iff (rst)
    cfg_req && !cfg_we && sel_stat |=>
    cfg_rdata[31:STAT_LSB+STAT_CAP_BIT+1] == 11'h000 &&
    cfg_rdata[STAT_LSB-1:0] == 16'h0000)
    else $error("status dword carries stray bits");

  // The hit flag follows the two served dwords, checked from the raw
  // address so that a broken decode cannot hide behind itself
  hit_served_a: assert property (@(posedge clk) disable iff (rst)
    cfg_req && (cfg_addr[DW_MSB:DW_LSB] == 6'h01 ||
    cfg_addr[DW_MSB:DW_LSB] == 6'h02) |=> cfg_ack && cfg_hit)
    else $error("served dword not flagged as hit");

  // Any other dword answers zero with no hit, so stray reads are visible
  miss_zero_a: assert property (@(posedge clk) disable iff (rst)
    cfg_req && cfg_addr[DW_MSB:DW_LSB] != 6'h01 &&
    cfg_addr[DW_MSB:DW_LSB] != 6'h02 |=>
    cfg_ack && !cfg_hit && cfg_rdata == 32'h0000_0000)
    else $error("unmapped dword answered wrongly");

  // Read data holds while no request is taken
  data_hold_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_req |=> $stable(cfg_rdata))
    else $error("read data moved without a request");

  // Reset leaves a quiet answer port, whatever was in flight
  reset_quiet_a: assert property (@(posedge clk)
    rst |=> !cfg_ack && !cfg_hit && cfg_rdata == 32'h0000_0000)
    else $error("answer port not cleared by reset");

endmodule

// File: verif/bcc_host.sv
// Upstream host model that issues dword configuration requests.
// Assumes the bench calls access() at a falling clock edge.
`timescale 1ns/1ns
module bcc_host (
  // Clock
  input wire logic clk,
  // Request toward the block
  output logic cfg_req,
  output logic cfg_we,
  output logic [bcc_pkg::ADDR_W-1:0] cfg_addr,
  output logic [bcc_pkg::BE_W-1:0] cfg_be,
  output logic [bcc_pkg::DATA_W-1:0] cfg_wdata,
  // Answer from the block
  input wire logic cfg_ack,
  input wire logic [bcc_pkg::DATA_W-1:0] cfg_rdata,
  input wire logic cfg_hit
);
  import bcc_pkg::*;
  // Idle bus at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'hF;
    cfg_wdata = 32'hFFFF_FFFF;
  end
  // One request; hold keeps the strobe up for a back-to-back follower,
  // otherwise the strobe drops and one idle clock passes before return
  task automatic access(input logic we, input logic [7:0] addr,
      input logic hold, output logic [31:0] data, output logic hit,
      output logic ok);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = addr;
    cfg_wdata = 32'hFFFF_FFFF;
    @(negedge clk);
    // Answer must stand at the falling edge half a cycle after the taking edge
    ok = (cfg_ack === 1'b1);
    data = cfg_rdata;
    hit = cfg_hit;
    if (!hold) begin
      // Released lines show garbage so stale values cannot pass
      cfg_req = 1'b0;
      cfg_addr = ~addr;
      cfg_wdata = 32'h0000_0000;
      @(negedge clk);
    end
  endtask
endmodule

// File: verif/bcc_class_regs_test.sv
// Self-checking bench for the identification dwords.
// Assumes bcc_host drives all configuration inputs.
`timescale 1ns/1ns
module bcc_class_regs_test;
  import bcc_pkg::*;
  // Arbitrary revision so the default cannot pass by accident
  localparam logic [7:0] REV = 8'h5A;
  localparam logic [31:0] CLS = {8'h06, 8'h04, 8'h00, REV};
  localparam logic [31:0] STS = 32'h0010_0000;
  typedef struct packed {
    logic we; logic [7:0] addr; logic [31:0] dat; logic hit;
  } bcc_row_s;
  // Reads, reads with low address bits set, writes, unmapped dword
  bcc_row_s rows [8] = '{
    '{1'b0, 8'h08, CLS, 1'b1}, '{1'b0, 8'h0B, CLS, 1'b1},
    '{1'b0, 8'h04, STS, 1'b1}, '{1'b0, 8'h07, STS, 1'b1},
    '{1'b1, 8'h08, 32'h0, 1'b1}, '{1'b0, 8'h08, CLS, 1'b1},
    '{1'b1, 8'h04, 32'h0, 1'b1}, '{1'b0, 8'h0C, 32'h0, 1'b0}};
  logic clk = 1'b0;
  logic rst, req, we, ack, hit, h, ok;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, d;
  int n_fail = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  bcc_class_regs #(.REVISION(REV)) i_bcc_class_regs (.clk(clk),
    .rst(rst), .cfg_req(req), .cfg_we(we), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wdata), .cfg_ack(ack), .cfg_rdata(rdata),
    .cfg_hit(hit));
  bcc_host i_bcc_host (.clk(clk), .cfg_req(req), .cfg_we(we),
    .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wdata), .cfg_ack(ack),
    .cfg_rdata(rdata), .cfg_hit(hit));
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    repeat (4) @(negedge clk);
    cmp32(rdata, 32'h0);
    cmp1(ack, 1'b0);
    cmp1(hit, 1'b0);
    rst = 1'b0;
    foreach (rows[i]) begin
      i_bcc_host.access(rows[i].we, rows[i].addr, 1'b0, d, h, ok);
      cmp1(ok, 1'b1);
      cmp32(d, rows[i].dat);
      cmp1(h, rows[i].hit);
    end
    // Back to back: write then read, then status then class word
    i_bcc_host.access(1'b1, 8'h08, 1'b1, d, h, ok);
    cmp32(d, 32'h0);
    cmp1(h, 1'b1);
    i_bcc_host.access(1'b0, 8'h08, 1'b1, d, h, ok);
    cmp32(d, CLS);
    i_bcc_host.access(1'b0, 8'h04, 1'b1, d, h, ok);
    cmp32(d, STS);
    cmp1(ok, 1'b1);
    i_bcc_host.access(1'b0, 8'h08, 1'b0, d, h, ok);
    cmp32(d, CLS);
    // Reset in mid-run clears the answer, then the word is intact
    rst = 1'b1;
    @(negedge clk);
    cmp1(ack, 1'b0);
    cmp32(rdata, 32'h0);
    rst = 1'b0;
    i_bcc_host.access(1'b0, 8'h08, 1'b0, d, h, ok);
    cmp32(d, CLS);
    cmp1(h, 1'b1);
    report_and_stop();
  end
endmodule
